// ---- rtl/bshs_defines.vh ----
// Constants for the status and high-set register bank of the step-down converter.
// Included by bare name by every design file of the bank; definitions only.
`ifndef BSHS_DEFINES_VH
`define BSHS_DEFINES_VH

// Seven-bit target address on the two-wire bus.
`define BSHS_I2C_ADDR 7'h1c
// Highest bus bit rate served, in kb/s; at 40 MHz one bit spans 100 clocks or more.
`define BSHS_I2C_MAX_KBPS 400
`define BSHS_CLK_MHZ 40
`define BSHS_MIN_BIT_CYCLES ((`BSHS_CLK_MHZ * 1000) / `BSHS_I2C_MAX_KBPS)

// Register offsets.
`define BSHS_REG_FAULT_STATUS 8'h01
`define BSHS_REG_HIGH_SET 8'h10

// Field positions.
`define BSHS_TSD_BIT 7
`define BSHS_PG_BIT 0
`define BSHS_GATE_BIT 7
`define BSHS_CODE_MSB 6

// Reset values.
`define BSHS_HIGH_SET_RESET 8'h97
`define BSHS_STATUS_RESET 8'h00

// Target level arithmetic in microvolts.
`define BSHS_LEVEL_BASE_UV 23'h04a015
`define BSHS_LEVEL_STEP_UV 23'h000c35
`define BSHS_LEVEL_W 23

`endif

// ---- rtl/bshs_level_calc.v ----
// Target output level arithmetic for the high-set level code.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "bshs_defines.vh"

module bshs_level_calc (
	input wire [6:0] code_in,
	input wire [1:0] bank_in,
	output wire [`BSHS_LEVEL_W-1:0] level_uv_out
);
	wire [`BSHS_LEVEL_W-1:0] code_ext;
	wire [`BSHS_LEVEL_W-1:0] step_sum;
	wire [`BSHS_LEVEL_W-1:0] ref_uv;

	// Base plus step times code, then doubled once per bank; peak is 5.6 V, within 23 bits.
	assign code_ext = {{(`BSHS_LEVEL_W-7){1'b0}}, code_in};
	assign step_sum = code_ext * `BSHS_LEVEL_STEP_UV;
	assign ref_uv = `BSHS_LEVEL_BASE_UV + step_sum;
	assign level_uv_out = ref_uv << bank_in;

endmodule
`default_nettype wire

// ---- rtl/bshs_top.v ----
// Status and high-set control register bank with its two-wire bus target.
// Assumes bus pins, status comparators and pins are synchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
`include "bshs_defines.vh"

module bshs_top (
	input wire clock_in,
	input wire sys_rst_in,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_out,
	input wire thermal_over_in,
	input wire vout_good_in,
	input wire set_select_pin_in,
	input wire enable_pin_in,
	input wire low_set_gate_in,
	input wire [1:0] bank_high_set_in,
	output reg converter_enable_out,
	output reg high_set_active_out,
	output reg [6:0] level_code_high_set_out,
	output reg [`BSHS_LEVEL_W-1:0] high_set_target_uv_out,
	output reg [7:0] high_set_reg_out,
	output reg [7:0] status_reg_out
);
	localparam [8:0] ST_IDLE = 9'h001;
	localparam [8:0] ST_ADDR = 9'h002;
	localparam [8:0] ST_ACK_A = 9'h004;
	localparam [8:0] ST_PTR = 9'h008;
	localparam [8:0] ST_ACK_P = 9'h010;
	localparam [8:0] ST_WDATA = 9'h020;
	localparam [8:0] ST_ACK_D = 9'h040;
	localparam [8:0] ST_RDATA = 9'h080;
	localparam [8:0] ST_RACK = 9'h100;

	reg [8:0] state_q;
	reg scl_q;
	reg sda_q;
	reg [7:0] shift_q;
	reg [3:0] bit_cnt_q;
	reg rw_q;
	reg nack_q;
	reg [7:0] ptr_q;
	reg [7:0] rd_q;
	reg [7:0] high_set_q;
	reg [7:0] status_q;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	wire byte_done;
	wire [`BSHS_LEVEL_W-1:0] level_uv;
	reg [7:0] rd_mux;

	// Bus edges; a slow bit rate only stretches the gaps between these events.
	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
	assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;
	assign byte_done = (bit_cnt_q == 4'h8);

	// Read data for the current pointer; reserved bits and unmapped offsets read zero.
	always @* begin
		rd_mux = 8'h00;
		if (ptr_q == `BSHS_REG_FAULT_STATUS)
			rd_mux = status_q;
		else if (ptr_q == `BSHS_REG_HIGH_SET)
			rd_mux = high_set_q;
	end

	bshs_level_calc u_level (
		.code_in(high_set_q[`BSHS_CODE_MSB:0]),
		.bank_in(bank_high_set_in),
		.level_uv_out(level_uv)
	);

	// Live status flags, refreshed every clock so a read sees the present condition.
	always @(posedge clock_in) begin
		if (sys_rst_in) begin
			status_q <= `BSHS_STATUS_RESET;
		end else begin
			status_q <= 8'h00;
			status_q[`BSHS_TSD_BIT] <= thermal_over_in;
			status_q[`BSHS_PG_BIT] <= vout_good_in;
		end
	end

	// Converter control outputs, all taken from flip-flops.
	always @(posedge clock_in) begin
		if (sys_rst_in) begin
			converter_enable_out <= 1'b0;
			high_set_active_out <= 1'b0;
			level_code_high_set_out <= 7'h00;
			high_set_target_uv_out <= {`BSHS_LEVEL_W{1'b0}};
			high_set_reg_out <= `BSHS_HIGH_SET_RESET;
			status_reg_out <= `BSHS_STATUS_RESET;
		end else begin
			if (set_select_pin_in)
				converter_enable_out <= enable_pin_in & high_set_q[`BSHS_GATE_BIT];
			else
				converter_enable_out <= enable_pin_in & low_set_gate_in;
			high_set_active_out <= set_select_pin_in;
			level_code_high_set_out <= high_set_q[`BSHS_CODE_MSB:0];
			high_set_target_uv_out <= level_uv;
			high_set_reg_out <= high_set_q;
			status_reg_out <= status_q;
		end
	end

	// Bus target: sample on clock rise, change data on clock fall, ack by pulling low.
	always @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_q <= ST_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			ptr_q <= 8'h00;
			rd_q <= 8'h00;
			high_set_q <= `BSHS_HIGH_SET_RESET;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			sda_out <= 1'b0;
			if (bus_stop) begin
				state_q <= ST_IDLE;
				sda_oe_out <= 1'b0;
			end else if (bus_start) begin
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_out <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						sda_oe_out <= 1'b0;
					end
					ST_ADDR, ST_PTR, ST_WDATA: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_in};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && byte_done) begin
							bit_cnt_q <= 4'h0;
							if (state_q == ST_ADDR) begin
								if (shift_q[7:1] == `BSHS_I2C_ADDR) begin
									rw_q <= shift_q[0];
									sda_oe_out <= 1'b1;
									state_q <= ST_ACK_A;
								end else begin
									state_q <= ST_IDLE;
								end
							end else if (state_q == ST_PTR) begin
								ptr_q <= shift_q;
								sda_oe_out <= 1'b1;
								state_q <= ST_ACK_P;
							end else begin
								// Only the writable register takes data; status is read-only.
								if (ptr_q == `BSHS_REG_HIGH_SET)
									high_set_q <= shift_q;
								ptr_q <= ptr_q + 8'h01;
								sda_oe_out <= 1'b1;
								state_q <= ST_ACK_D;
							end
						end
					end
					ST_ACK_A: begin
						if (scl_fall) begin
							if (rw_q) begin
								rd_q <= rd_mux;
								sda_oe_out <= ~rd_mux[7];
								ptr_q <= ptr_q + 8'h01;
								state_q <= ST_RDATA;
							end else begin
								sda_oe_out <= 1'b0;
								state_q <= ST_PTR;
							end
						end
					end
					ST_ACK_P, ST_ACK_D: begin
						if (scl_fall) begin
							sda_oe_out <= 1'b0;
							state_q <= ST_WDATA;
						end
					end
					ST_RDATA: begin
						if (scl_rise) begin
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall) begin
							if (byte_done) begin
								bit_cnt_q <= 4'h0;
								sda_oe_out <= 1'b0;
								state_q <= ST_RACK;
							end else begin
								sda_oe_out <= ~rd_q[6];
								rd_q <= {rd_q[6:0], 1'b0};
							end
						end
					end
					ST_RACK: begin
						// A high level at the ack bit ends the read burst.
						if (scl_rise) begin
							nack_q <= sda_in;
						end else if (scl_fall) begin
							if (nack_q) begin
								state_q <= ST_IDLE;
							end else begin
								rd_q <= rd_mux;
								sda_oe_out <= ~rd_mux[7];
								ptr_q <= ptr_q + 8'h01;
								state_q <= ST_RDATA;
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
						sda_oe_out <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ---- tb/bshs_chk_assertions.sv ----
// Port checker for the status and high-set bank.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module bshs_chk (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_oe_out,
	input wire logic thermal_over_in,
	input wire logic vout_good_in,
	input wire logic set_select_pin_in,
	input wire logic enable_pin_in,
	input wire logic [1:0] bank_high_set_in,
	input wire logic converter_enable_out,
	input wire logic [6:0] level_code_high_set_out,
	input wire logic [22:0] high_set_target_uv_out,
	input wire logic [7:0] high_set_reg_out,
	input wire logic [7:0] status_reg_out
);
	// All checks share the clock and sleep through reset.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	// Both pins high one clock before the gate bit shows on the copy port.
	sequence s_sel_en;
		set_select_pin_in && enable_pin_in;
	endsequence
	chk_tsd_flag: assert property (thermal_over_in [*3] |-> status_reg_out[7])
		else $error("tsd");
	chk_pg_flag: assert property (!vout_good_in [*3] |-> !status_reg_out[0])
		else $error("pg");
	chk_rsvd_zero: assert property (status_reg_out[6:1] == 6'h00) else $error("rsvd");
	chk_gate_on: assert property (
		s_sel_en ##1 high_set_reg_out[7] |-> converter_enable_out) else $error("on");
	chk_gate_off: assert property (
		set_select_pin_in ##1 !high_set_reg_out[7] |-> !converter_enable_out) else $error("off");
	chk_code_copy: assert property (
		!$past(sys_rst_in) |-> level_code_high_set_out == high_set_reg_out[6:0]) else $error("code");
	chk_target_calc: assert property (!$past(sys_rst_in) |-> high_set_target_uv_out ==
		(23'd303125 + 23'd3125 * high_set_reg_out[6:0]) << $past(bank_high_set_in)) else $error("uv");
	chk_ack_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("oe");
endmodule
bind bshs_top bshs_chk bshs_chk_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
	.scl_in(scl_in), .sda_oe_out(sda_oe_out), .thermal_over_in(thermal_over_in),
	.vout_good_in(vout_good_in), .set_select_pin_in(set_select_pin_in),
	.enable_pin_in(enable_pin_in), .bank_high_set_in(bank_high_set_in),
	.converter_enable_out(converter_enable_out),
	.level_code_high_set_out(level_code_high_set_out),
	.high_set_target_uv_out(high_set_target_uv_out),
	.high_set_reg_out(high_set_reg_out), .status_reg_out(status_reg_out));
`default_nettype wire

// ---- tb/bshs_i2c_host.sv ----
// Bus host model: drives the bus clock and pulls data low.
// Assumes a pull-up on data, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module bshs_i2c_host (
	input wire logic clk,
	input wire logic dev_oe,
	output logic scl,
	output wire logic sda
);
	logic pull_q = 1'b0;
	initial scl = 1'b1;
	// Wired-and of both parties.
	assign sda = ~(pull_q | dev_oe);
	// A quarter bit is 25 clocks, so a bit takes 100 clocks and stays within 400 kb/s.
	task automatic step(input logic c, input logic p);
		scl = c;
		pull_q = p;
		repeat (25) @(negedge clk);
	endtask
	// Four clock and pull pairs, first pair on top: start is 8'h2f, stop is 8'h5e.
	task automatic cond(input logic [7:0] s);
		for (int i = 6; i >= 0; i -= 2) step(s[i+1], s[i]);
	endtask
	// Nine bits MSB first; the ninth is the acknowledge, sampled late in the high phase.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			repeat (2) step(1'b0, ~d[i]);
			repeat (2) step(1'b1, ~d[i]);
			q[i] = sda;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/buck_status_and_high_set_regs_tb.sv ----
// Bench for the status and high-set bank.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module buck_status_and_high_set_regs_tb;
	logic clock_in, sys_rst_in, thermal_over_in, vout_good_in, set_select_pin_in;
	logic enable_pin_in, low_set_gate_in;
	logic [1:0] bank_high_set_in;
	logic [7:0] v;
	wire scl, sda, oe, conv, sdo, act;
	wire [6:0] code;
	wire [22:0] uv;
	wire [7:0] hs;
	int num_errors = 0;
	int samples_checked = 0;
	// Design and host model share the wired data line.
	bshs_top bshs_top_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sdo), .sda_oe_out(oe), .thermal_over_in(thermal_over_in),
		.vout_good_in(vout_good_in), .set_select_pin_in(set_select_pin_in),
		.enable_pin_in(enable_pin_in), .low_set_gate_in(low_set_gate_in),
		.bank_high_set_in(bank_high_set_in), .converter_enable_out(conv),
		.high_set_active_out(act), .level_code_high_set_out(code),
		.high_set_target_uv_out(uv), .high_set_reg_out(hs), .status_reg_out());
	bshs_i2c_host host_i (.clk(clock_in), .dev_oe(oe), .scl(scl), .sda(sda));
	// The 40 MHz clock.
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One access; a read re-addresses after a repeated start and ends with a refusal.
	task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
		logic [8:0] q;
		host_i.cond(8'h2f);
		host_i.xfer({7'h1c, 2'b01}, q);
		check(q[0], 1'b0);
		host_i.xfer({a, 1'b1}, q);
		if (rd) host_i.cond(8'h2f);
		if (rd) host_i.xfer({7'h1c, 2'b11}, q);
		host_i.xfer(rd ? 9'h1ff : {d, 1'b1}, q);
		v = q[8:1];
		host_i.cond(8'h5e);
	endtask
	// Reset value, then a write to the status register that must change nothing.
	task automatic t_regs;
		acc(1'b1, 8'h10, 8'h00);
		check(v, 8'h97);
		acc(1'b0, 8'h01, 8'hfe);
		check(hs, 8'h97);
		check(sdo, 1'b0);
	endtask
	// A neighbouring address gets no acknowledge, and the bytes that follow change nothing.
	task automatic t_addr;
		logic [8:0] q;
		host_i.cond(8'h2f);
		host_i.xfer({7'h1d, 2'b01}, q);
		check(q[0], 1'b1);
		host_i.xfer({8'h10, 1'b1}, q);
		host_i.xfer({8'h00, 1'b1}, q);
		host_i.cond(8'h5e);
		check(hs, 8'h97);
	endtask
	// All four flag pairs, with reserved bits reading zero.
	task automatic t_status;
		for (int i = 0; i < 4; i++) begin
			{thermal_over_in, vout_good_in} = i[1:0];
			acc(1'b1, 8'h01, 8'h00);
			check(v, {i[1], 6'h00, i[0]});
		end
	endtask
	// Gate closed then open, target over all banks, then the pin selects the other set.
	task automatic t_level;
		{set_select_pin_in, enable_pin_in, low_set_gate_in} = 3'b111;
		acc(1'b0, 8'h10, 8'h55);
		check(conv, 1'b0);
		check(code, 7'h55);
		check(act, 1'b1);
		acc(1'b0, 8'h10, 8'hff);
		check(conv, 1'b1);
		for (int b = 0; b < 4; b++) begin
			bank_high_set_in = b[1:0];
			repeat (2) @(negedge clock_in);
			check(uv, (32'd303125 + 32'd3125 * 32'd127) << b);
		end
		{set_select_pin_in, low_set_gate_in} = 2'b00;
		repeat (2) @(negedge clock_in);
		check(conv, 1'b0);
		check(act, 1'b0);
	endtask
	// Reset for six clocks, then the scenarios in turn.
	initial begin
		{sys_rst_in, thermal_over_in, vout_good_in} = 3'b100;
		{set_select_pin_in, enable_pin_in, low_set_gate_in, bank_high_set_in} = 5'h00;
		repeat (6) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (2) @(negedge clock_in);
		t_regs;
		t_addr;
		t_status;
		t_level;
		end_of_test;
	end
	// About two and a half times the expected run time.
	initial begin
		repeat (80000) @(posedge clock_in);
		num_errors++;
		end_of_test;
	end
endmodule
`default_nettype wire
